// File: design/hsp_cfg.svh
// Constants for the host serial / I2C port: offsets, fields, resets, timing
`ifndef HSP_CFG_SVH
`define HSP_CFG_SVH
`define HSP_PIN_STATUS_ADDR 7'h02
`define HSP_SELECT_CFG_ADDR 7'h7F
`define HSP_MODE_BIT 0
`define HSP_SELECT_RESET 8'h00
`define HSP_MODE_DELAY_NS 10000
`define HSP_CLK_PERIOD_NS 10
`define HSP_MODE_DELAY_CYC (`HSP_MODE_DELAY_NS / `HSP_CLK_PERIOD_NS)
`define HSP_I2C_BASE_ADDR 4'h5
`define HSP_SER_FRAME_BITS 16
`endif

// File: design/hsp_host_port.sv
// Host control port: serial (chip select) or I2C target, with mode select
`timescale 1ns/1ps
`default_nettype none
`include "hsp_cfg.svh"

// Behaviour
// - Two modes, I2C target and clocked serial; shared pins follow mode.
// - During reset the mode pin level loads select bit 0; 1 is serial.
// - After reset mode pin is only an input; select bit sets mode.
// - Selected mode becomes active 10 us after reset release.
// - Pin status bit 0 always mirrors the present mode pin level.
// - Serial output updates on falling edge if edge select high.
// - Serial input sampled on rising shift clock edge, address then data.
// - Serial output changes on the selected edge, one bit each, and clears to 0 when chip select goes high.
// - I2C target answers only addresses matching the three address pins.
// - In I2C mode data pin is open-drain data, clock pin is bus clock.
module hsp_host_port
  import hsp_pkg::*;
#(
  parameter int MODE_DELAY_CYC = `HSP_MODE_DELAY_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic host_if_mode_pin_i,
  input wire logic shift_edge_select_i,
  input wire logic serial_in_pin_i,
  input wire logic sclk_scl_i,
  input wire logic cs_addr0_i,
  input wire logic target_addr_pin1_i,
  input wire logic target_addr_pin2_i,
  input wire logic sdo_sda_i,
  output logic sdo_sda_o,
  output logic sdo_sda_oe_o,
  output logic serial_mode_o,
  output logic port_ready_o
);

  // Two-flop synchronisers; first stage read only by the second
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  wire [7:0] pins_w = {host_if_mode_pin_i, shift_edge_select_i,
    serial_in_pin_i, sclk_scl_i, cs_addr0_i, sdo_sda_i,
    target_addr_pin2_i, target_addr_pin1_i};
  always_ff @(posedge ref_clk_i)
  begin
    meta_reg <= pins_w;
    sync_reg <= meta_reg;
  end
  wire mode_s = sync_reg[7];
  wire edge_sel_s = sync_reg[6];
  wire sdi_s = sync_reg[5];
  wire sck_s = sync_reg[4];
  wire cs_s = sync_reg[3];
  wire sda_s = sync_reg[2];
  wire ad2_s = sync_reg[1];
  wire ad1_s = sync_reg[0];

  // Edge detection on the sampled link clock and data
  logic sck_d_reg;
  logic sda_d_reg;
  logic cs_d_reg;
  always_ff @(posedge ref_clk_i)
  begin
    sck_d_reg <= sck_s;
    sda_d_reg <= sda_s;
    cs_d_reg <= cs_s;
  end
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;
  wire sda_rise = sda_s & ~sda_d_reg;
  wire sda_fall = ~sda_s & sda_d_reg;

  // Registers: select config and read-only pin status
  logic [7:0] select_cfg_reg;
  logic [7:0] pin_status_reg;
  logic in_reset_reg;
  logic [15:0] delay_cnt_reg;
  logic ready_reg;

  // Mode pin caught on clocks while reset is held
  always_ff @(posedge ref_clk_i)
  begin
    in_reset_reg <= ~rst_n_i;
    pin_status_reg <= {7'h00, mode_s};
  end

  // Mode activation delay after release
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      delay_cnt_reg <= 16'h0000;
      ready_reg <= 1'b0;
    end
    else if (!ready_reg)
    begin
      delay_cnt_reg <= delay_cnt_reg + 16'h0001;
      ready_reg <= (delay_cnt_reg == 16'(MODE_DELAY_CYC - 1));
    end
  end

  wire ser_mode = select_cfg_reg[`HSP_MODE_BIT];
  wire ser_act = ready_reg & ser_mode;
  wire i2c_act = ready_reg & ~ser_mode;

  // Register read selection shared by both transports
  function automatic logic [7:0] reg_read(input logic [6:0] a,
    input logic [7:0] sel, input logic [7:0] sts);
    reg_read = (a == `HSP_PIN_STATUS_ADDR) ? sts :
      (a == `HSP_SELECT_CFG_ADDR) ? sel : 8'h00;
  endfunction : reg_read

  // Serial side: R/W flag, 7-bit address, 8-bit data
  logic [4:0] sbit_reg;
  logic [15:0] sshift_reg;
  logic [7:0] sout_reg;
  logic sdo_reg;
  wire s_upd = edge_sel_s ? sck_fall : sck_rise;
  wire s_take = ser_act & ~cs_s & sck_rise;
  wire [15:0] s_word = {sshift_reg[14:0], sdi_s};
  wire s_addr_done = s_take & (sbit_reg == 5'd7);
  wire s_wr_done = s_take & (sbit_reg == 5'(`HSP_SER_FRAME_BITS - 1))
    & ~sshift_reg[14];

  // I2C side
  hsp_i2c_state_e ist_reg;
  logic [3:0] ibit_reg;
  logic [7:0] ishift_reg;
  logic [6:0] iaddr_reg;
  logic [7:0] iout_reg;
  logic ifirst_reg;
  logic sda_low_reg;
  wire [6:0] my_addr = {`HSP_I2C_BASE_ADDR, ad2_s,
    ad1_s, cs_s};
  wire i_start = i2c_act & sck_s & sda_fall;
  wire i_stop = i2c_act & sck_s & sda_rise;
  wire [7:0] i_byte = {ishift_reg[6:0], sda_s};
  wire i_wr = (ist_reg == HSP_I_DATA) & sck_rise & (ibit_reg == 4'd7)
    & ~ifirst_reg;

  // Select register: pin level while in reset, then software writes
  always_ff @(posedge ref_clk_i)
  begin
    if (in_reset_reg)
      select_cfg_reg <= {7'h00, mode_s};
    else if (s_wr_done && s_word[14:8] == `HSP_SELECT_CFG_ADDR)
      select_cfg_reg <= s_word[7:0];
    else if (i_wr && iaddr_reg == `HSP_SELECT_CFG_ADDR)
      select_cfg_reg <= i_byte;
  end

  // Serial shifter and output
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || cs_s || !ser_act)
    begin
      sbit_reg <= 5'd0;
      sshift_reg <= 16'h0000;
      sout_reg <= 8'h00;
      sdo_reg <= 1'b0;
    end
    else
    begin
      if (s_take)
      begin
        sshift_reg <= s_word;
        sbit_reg <= sbit_reg + 5'd1;
      end
      if (s_addr_done)
        sout_reg <= reg_read(s_word[6:0], select_cfg_reg, pin_status_reg);
      else if (s_upd && sbit_reg >= 5'd8)
      begin
        sdo_reg <= sout_reg[7];
        sout_reg <= {sout_reg[6:0], 1'b0};
      end
    end
  end

  // I2C target: address match, register pointer, data byte
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !i2c_act || i_stop)
    begin
      ist_reg <= HSP_I_IDLE;
      ibit_reg <= 4'd0;
      ishift_reg <= 8'h00;
      iaddr_reg <= 7'h00;
      iout_reg <= 8'h00;
      ifirst_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end
    else if (i_start)
    begin
      ist_reg <= HSP_I_ADDR;
      ibit_reg <= 4'd0;
      ifirst_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end
    else
    begin
      case (ist_reg)
        HSP_I_ADDR, HSP_I_DATA:
        begin
          if (sck_rise)
          begin
            ishift_reg <= i_byte;
            ibit_reg <= ibit_reg + 4'd1;
          end
          if (sck_fall && ibit_reg == 4'd8)
          begin
            ibit_reg <= 4'd0;
            if (ist_reg == HSP_I_ADDR && ishift_reg[7:1] != my_addr)
              ist_reg <= HSP_I_IDLE;
            else
            begin
              sda_low_reg <= 1'b1;
              ist_reg <= (ist_reg == HSP_I_ADDR) ? HSP_I_AACK : HSP_I_DACK;
            end
            if (ist_reg == HSP_I_ADDR)
              iout_reg <= reg_read(iaddr_reg, select_cfg_reg,
                pin_status_reg);
            if (ist_reg == HSP_I_DATA && ifirst_reg)
              iaddr_reg <= ishift_reg[6:0];
          end
        end
        HSP_I_AACK, HSP_I_DACK:
        begin
          if (sck_fall)
          begin
            ifirst_reg <= (ist_reg == HSP_I_AACK);
            if (ist_reg == HSP_I_AACK && ishift_reg[0])
            begin
              ist_reg <= HSP_I_RDAT;
              sda_low_reg <= ~iout_reg[7];
              iout_reg <= {iout_reg[6:0], 1'b1};
            end
            else
            begin
              ist_reg <= HSP_I_DATA;
              sda_low_reg <= 1'b0;
            end
          end
        end
        HSP_I_RDAT:
        begin
          if (sck_fall)
          begin
            ibit_reg <= ibit_reg + 4'd1;
            if (ibit_reg == 4'd7)
            begin
              ist_reg <= HSP_I_RACK;
              sda_low_reg <= 1'b0;
            end
            else
            begin
              sda_low_reg <= ~iout_reg[7];
              iout_reg <= {iout_reg[6:0], 1'b1};
            end
          end
        end
        HSP_I_RACK:
        begin
          if (sck_rise)
            ist_reg <= HSP_I_IDLE; // Single-byte read, then wait for stop
        end
        default: ist_reg <= HSP_I_IDLE;
      endcase
    end
  end

  // Shared pin drive: push-pull in serial, open-drain low in I2C
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sdo_sda_o <= 1'b0;
      sdo_sda_oe_o <= 1'b0;
      serial_mode_o <= 1'b0;
      port_ready_o <= 1'b0;
    end
    else
    begin
      sdo_sda_o <= ser_act ? sdo_reg : 1'b0;
      sdo_sda_oe_o <= ser_act ? ~cs_s : sda_low_reg;
      serial_mode_o <= ser_mode;
      port_ready_o <= ready_reg;
    end
  end

endmodule : hsp_host_port
`default_nettype wire

// File: design/hsp_pkg.sv
// Types shared by the host serial / I2C port
package hsp_pkg;
  typedef enum logic [2:0]
  {
    HSP_I_IDLE = 3'h0,
    HSP_I_ADDR = 3'h1,
    HSP_I_AACK = 3'h3,
    HSP_I_DATA = 3'h2,
    HSP_I_DACK = 3'h6,
    HSP_I_RDAT = 3'h7,
    HSP_I_RACK = 3'h5
  } hsp_i2c_state_e;
endpackage : hsp_pkg

// File: verification/hsp_host_model.sv
// Host processor model: serial frames and I2C address phases
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
  input wire logic clk_i,
  input wire logic edge_i,
  input wire logic sda_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic sda_low_o
);
  // Idle: shift clock stands low, chip select high, data released
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // Half of a 160 ns shift period, launched off the falling edge
  task automatic half;
    repeat (8) @(negedge clk_i);
  endtask : half
  // Frame MSB first; SERIAL_OUT_PIN taken just before the edge opposite its update
  task automatic ser(input logic [15:0] w, output logic [7:0] r);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_o = w[i];
      half();
      if (i < 8 && edge_i) r[i] = sda_i;
      sclk_o = 1'b1;
      half();
      if (i < 8 && !edge_i) r[i] = sda_i;
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    half();
  endtask : ser
  // START or repeated START: data falls while the bus clock stands high
  task automatic i2c_start;
    sclk_o = 1'b0;
    sda_low_o = 1'b0;
    half();
    sclk_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
  endtask : i2c_start
  // One byte MSB first, then the ninth clock with data released
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      sda_low_o = ~b[i];
      half();
      sclk_o = 1'b1;
      half();
    end
    sclk_o = 1'b0;
    sda_low_o = 1'b0;
    half();
    ack = ~sda_i;
    sclk_o = 1'b1;
    half();
  endtask : i2c_byte
  // Eight bits taken before each rise, then a NACK clock
  task automatic i2c_read(output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      sda_low_o = 1'b0;
      half();
      d[i] = sda_i;
      sclk_o = 1'b1;
      half();
    end
    sclk_o = 1'b0;
    half();
    sclk_o = 1'b1;
    half();
  endtask : i2c_read
  // STOP, then the clock is parked low for a full half period
  task automatic i2c_stop;
    sclk_o = 1'b0;
    sda_low_o = 1'b1;
    half();
    sclk_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
    sclk_o = 1'b0;
    half();
  endtask : i2c_stop
  // Address phase alone: START, address byte, STOP
  task automatic i2c(input logic [7:0] a, output logic ack);
    i2c_start();
    i2c_byte(a, ack);
    i2c_stop();
  endtask : i2c
endmodule : hsp_host_model
`default_nettype wire

// File: verification/hsp_host_port_checker.sv
// Assertion checker for the host serial / I2C port
`timescale 1ns/1ps
`default_nettype none
module hsp_host_port_checker #(
  parameter int MODE_DELAY_CYC = 1000
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic host_if_mode_pin_i,
  input wire logic shift_edge_select_i,
  input wire logic sclk_scl_i,
  input wire logic cs_addr0_i,
  input wire logic sdo_sda_o,
  input wire logic sdo_sda_oe_o,
  input wire logic serial_mode_o,
  input wire logic port_ready_o
);
  logic [15:0] cnt;
  logic [1:0] sk;
  logic [3:0] since;
  wire logic sel_edge;
  // Selected shift edge as seen after one sampling flop
  assign sel_edge = shift_edge_select_i ? (sk == 2'b10) : (sk == 2'b01);
  // Counters saturate so long runs never wrap into a false pass
  always_ff @(posedge ref_clk_i)
  begin
    sk <= {sk[0], sclk_scl_i};
    cnt <= !rst_n_i ? 16'h0000 : cnt + {15'h0000, cnt != 16'hFFFF};
    since <= (!rst_n_i || sel_edge) ? 4'h0 : since + {3'h0, since != 4'hF};
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ready_early;
    port_ready_o |-> cnt >= MODE_DELAY_CYC - 1;
  endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready early");
  property p_ready_late;
    cnt >= MODE_DELAY_CYC + 4 |-> port_ready_o;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready late");
  property p_mode_load;
    $rose(rst_n_i) |-> ##2 serial_mode_o == $past(host_if_mode_pin_i, 4);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode load");
  property p_mode_hold;
    serial_mode_o && cs_addr0_i && $past(cs_addr0_i) |=> serial_mode_o;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_sdo_edge;
    serial_mode_o && !cs_addr0_i && $changed(sdo_sda_o) |-> since <= 4'h6;
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("sdo edge");
  property p_oe_on;
    serial_mode_o && $fell(cs_addr0_i) |-> ##[1:6] sdo_sda_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe missing");
  property p_oe_off;
    (serial_mode_o && cs_addr0_i) [*6] |-> !sdo_sda_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  property p_i2c_low;
    (!serial_mode_o) [*3] |-> !sdo_sda_o;
  endproperty
  a_i2c_low: assert property (p_i2c_low) else $error("sda driven");
  property p_ack_scl;
    !serial_mode_o && $rose(sdo_sda_oe_o) |-> !sclk_scl_i;
  endproperty
  a_ack_scl: assert property (p_ack_scl) else $error("ack timing");
endmodule : hsp_host_port_checker
bind hsp_host_port hsp_host_port_checker #(.MODE_DELAY_CYC(MODE_DELAY_CYC))
  i_chk (.ref_clk_i, .rst_n_i, .host_if_mode_pin_i, .shift_edge_select_i,
  .sclk_scl_i, .cs_addr0_i, .sdo_sda_o, .sdo_sda_oe_o, .serial_mode_o,
  .port_ready_o);
`default_nettype wire

// File: verification/hsp_host_port_tb.sv
// Testbench for the host serial / I2C port
`timescale 1ns/1ps
`default_nettype none
module hsp_host_port_tb;
  logic clk, rst_n, mode_pin, edge_sel, ad1, ad2, ack;
  logic [7:0] rd;
  wire logic sclk, cs_n, serial_in_pin, sda_low, sda, serial_out_pin, oe, ser_mode, ready;
  int n_errors = 0;
  int comparisons = 0;
  // Shared wire: pull-down in serial mode, pull-up in I2C mode
  assign sda = oe ? (ser_mode & serial_out_pin) : (!ser_mode & !sda_low);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  hsp_host_port #(.MODE_DELAY_CYC(20)) i_dut (.ref_clk_i(clk),
    .rst_n_i(rst_n), .host_if_mode_pin_i(mode_pin),
    .shift_edge_select_i(edge_sel), .serial_in_pin_i(serial_in_pin), .sclk_scl_i(sclk),
    .cs_addr0_i(cs_n), .target_addr_pin1_i(ad1), .target_addr_pin2_i(ad2),
    .sdo_sda_i(sda), .sdo_sda_o(serial_out_pin), .sdo_sda_oe_o(oe),
    .serial_mode_o(ser_mode), .port_ready_o(ready));
  hsp_host_model i_host (.clk_i(clk), .edge_i(edge_sel), .sda_i(sda),
    .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in_pin), .sda_low_o(sda_low));
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Reset with the mode pin held, then wait a bounded time for ready
  task automatic do_reset(input logic pin);
    int k;
    rst_n = 1'b0;
    mode_pin = pin;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 100 && ready !== 1'b1; k++) @(negedge clk);
    chk("ready", 8'h01, {7'h00, ready});
  endtask : do_reset
  initial
  begin
    rst_n = 1'b0;
    edge_sel = 1'b0;
    ad1 = 1'b0;
    ad2 = 1'b0;
    do_reset(1'b1);
    chk("mode", 8'h01, {7'h00, ser_mode});
    for (int e = 0; e < 2; e++)
    begin
      edge_sel = e[0];
      i_host.ser(16'hFF00, rd);
      chk("select", 8'h01, rd);
    end
    mode_pin = 1'b0;
    i_host.ser(16'h02FF, rd);
    i_host.ser(16'h8200, rd);
    chk("pin status", 8'h00, rd);
    i_host.ser(16'h9000, rd);
    chk("unmapped", 8'h00, rd);
    chk("mode held", 8'h01, {7'h00, ser_mode});
    mode_pin = 1'b1;
    i_host.ser(16'h8200, rd);
    chk("pin status", 8'h01, rd);
    i_host.ser(16'h7F00, rd);
    chk("i2c mode", 8'h00, {7'h00, ser_mode});
    i_host.i2c(8'h52, ack);
    chk("ack own", 8'h01, {7'h00, ack});
    ad2 = 1'b1;
    i_host.i2c(8'h52, ack);
    chk("ack other", 8'h00, {7'h00, ack});
    i_host.i2c(8'h5A, ack);
    chk("ack moved", 8'h01, {7'h00, ack});
    i_host.i2c_start();
    i_host.i2c_byte(8'h5A, ack);
    i_host.i2c_byte(8'h02, ack);
    chk("ptr ack", 8'h01, {7'h00, ack});
    i_host.i2c_start();
    i_host.i2c_byte(8'h5B, ack);
    i_host.i2c_read(rd);
    i_host.i2c_stop();
    chk("i2c pin status", 8'h01, rd);
    i_host.i2c_start();
    i_host.i2c_byte(8'h5A, ack);
    i_host.i2c_byte(8'h7F, ack);
    i_host.i2c_byte(8'h01, ack);
    i_host.i2c_stop();
    chk("i2c write", 8'h01, {7'h00, ser_mode});
    ad2 = 1'b0;
    i_host.ser(16'hFF00, rd);
    chk("select", 8'h01, rd);
    do_reset(1'b0);
    chk("mode", 8'h00, {7'h00, ser_mode});
    i_host.i2c(8'h52, ack);
    chk("ack reset", 8'h01, {7'h00, ack});
    tally_and_finish();
  end
endmodule : hsp_host_port_tb
`default_nettype wire
